// file: pkg/sfw_map.vh
/*
 * Constants for the store-to-load forwarding block: load result codes,
 * drain states, replay penalty and predictor counter values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SFW_MAP_VH
`define SFW_MAP_VH

// Load completion status codes
`define SFW_ST_FWD 2'h0
`define SFW_ST_MEM 2'h1
`define SFW_ST_REJ 2'h2

// Drain state machine codes
`define SFW_DR_IDLE 2'h0
`define SFW_DR_READ 2'h1
`define SFW_DR_WRITE 2'h2

// Cycles lost when an unpredicted load meets missing store data
`define SFW_REPLAY_CYC 8'h0C

// Predictor counter reset value and saturation limit
`define SFW_PRED_INIT 2'h1
`define SFW_PRED_MAX 2'h3

// Width of a data word and of its byte offset
`define SFW_DATA_W 64
`define SFW_OFF_W 3

`endif

// file: src/sfw_stq_mem.v
/*
 * Store data array of the store buffer: one write port, two registered
 * read ports (forwarding and drain).
 * Assumes the owner tracks which entries hold valid data.
 */
`timescale 1ns/10ps

module sfw_stq_mem #(
	parameter DW = 64,
	parameter N = 8,
	parameter IW = 3
) (
	input wire clock,
	input wire wr_en,
	input wire [IW-1:0] wr_idx,
	input wire [DW-1:0] wr_data,
	input wire [IW-1:0] rd_a_idx,
	output reg [DW-1:0] rd_a_data,
	input wire [IW-1:0] rd_b_idx,
	output reg [DW-1:0] rd_b_data
);

	reg [DW-1:0] mem [0:N-1];

	always @(posedge clock)
	begin
		if (wr_en)
		begin
			mem[wr_idx] <= wr_data;
		end
		// Reads see the old word on a same-cycle write
		rd_a_data <= mem[rd_a_idx];
		rd_b_data <= mem[rd_b_idx];
	end

endmodule // sfw_stq_mem

// file: src/sfw_pred.v
/*
 * Store-dependence predictor: saturating two-bit counters indexed by
 * low program counter bits of the load instruction.
 * Assumes one update per cycle from the forwarding pipeline.
 */
`timescale 1ns/10ps
`include "sfw_map.vh"

module sfw_pred #(
	parameter ENTRIES = 16,
	parameter IW = 4
) (
	input wire clock,
	input wire rst,
	input wire [IW-1:0] rd_idx,
	output wire rd_dep,
	input wire upd_valid,
	input wire [IW-1:0] upd_idx,
	input wire upd_dep
);

	reg [1:0] ctr_q [0:ENTRIES-1];
	integer i;

	// Upper counter bit says dependent
	assign rd_dep = ctr_q[rd_idx][1];

	always @(posedge clock)
	begin
		if (rst)
		begin
			for (i = 0; i < ENTRIES; i = i + 1)
			begin
				ctr_q[i] <= `SFW_PRED_INIT;
			end
		end
		else if (upd_valid)
		begin
			if (upd_dep && ctr_q[upd_idx] != `SFW_PRED_MAX)
			begin
				ctr_q[upd_idx] <= ctr_q[upd_idx] + 2'h1;
			end
			else if (!upd_dep && ctr_q[upd_idx] != 2'h0)
			begin
				ctr_q[upd_idx] <= ctr_q[upd_idx] - 2'h1;
			end
		end
	end

endmodule // sfw_pred

// file: src/sfw_top.v
/*
 * Store-to-load forwarding: store buffer with in-order retire and drain,
 * load comparison, forwarding, blocking, replay and dependence prediction.
 * Assumes one core clock, stores allocated in program order, every
 * buffered store older than each load presented, and a cache that
 * answers a read in the same cycle as mem_rd_valid requests it.
 */
`timescale 1ns/10ps
`include "sfw_map.vh"

// Operation
// - Same-start load no wider than store gets store data, unblocked.
// - Narrow load inside wider store at other start is blocked.
// - Forwardable younger load completes past older blocked load.
// - Load needing bytes of several stores is not forwarded.
// - Wide load over small stores waits for their drain, reads memory.
// - Misaligned narrow load waits for store drain, reads memory.
// - Load waits until forwarding store's data exists.
// - Predict store-dependent loads and schedule them by it.
// - Unpredicted early load replays once data lands and its penalty, counted from capture, ends.
// - Youngest matching store supplies data over older wider one.
// - Forwarding needs equal start addresses.
// - Forwarding needs every load byte inside the store.
// - Loads overlapping no store go straight to memory.
// - Stores drain to memory only after retirement.
module sfw_top #(
	parameter AW = 32,
	parameter N = 8,
	parameter IW = 3,
	parameter TW = 6,
	parameter PN = 16,
	parameter PIW = 4
) (
	input wire clock,
	input wire rst,
	input wire st_alloc_valid,
	input wire [AW-1:0] st_alloc_addr,
	input wire [1:0] st_alloc_size,
	output reg st_alloc_ready,
	output reg [IW-1:0] st_alloc_idx,
	input wire st_data_valid,
	input wire [IW-1:0] st_data_idx,
	input wire [`SFW_DATA_W-1:0] st_data,
	input wire st_retire,
	output reg mem_wr_valid,
	output reg [AW-1:0] mem_wr_addr,
	output reg [1:0] mem_wr_size,
	output reg [`SFW_DATA_W-1:0] mem_wr_data,
	input wire mem_wr_ready,
	input wire ld_valid,
	input wire [AW-1:0] ld_addr,
	input wire [1:0] ld_size,
	input wire [TW-1:0] ld_tag,
	input wire [AW-1:0] ld_pc,
	output reg mem_rd_valid,
	output reg [AW-1:0] mem_rd_addr,
	input wire [`SFW_DATA_W-1:0] mem_rd_data,
	output reg ld_done_valid,
	output reg [TW-1:0] ld_done_tag,
	output reg [1:0] ld_done_status,
	output reg [`SFW_DATA_W-1:0] ld_done_data,
	output reg slot_busy
);

	function [3:0] sfw_bytes;
		input [1:0] s;
		begin
			sfw_bytes = 4'h1 << s;
		end
	endfunction

	function [`SFW_DATA_W-1:0] sfw_mask;
		input [1:0] s;
		begin
			sfw_mask = {`SFW_DATA_W{1'b1}} >> ((4'h8 - sfw_bytes(s)) * 8);
		end
	endfunction

	// Store buffer state
	reg v_q [0:N-1];
	reg ret_q [0:N-1];
	reg dv_q [0:N-1];
	reg [AW-1:0] a_q [0:N-1];
	reg [1:0] sz_q [0:N-1];
	reg [IW-1:0] head_q;
	reg [IW-1:0] rp_q;
	reg [IW:0] cnt_q;
	reg [IW:0] cnt_d;
	reg [1:0] dr_q;
	wire pop;
	wire alloc;

	// Held load slot
	reg [AW-1:0] sl_a_q;
	reg [1:0] sl_sz_q;
	reg [TW-1:0] sl_tag_q;
	reg sl_pred_q;
	reg [7:0] sl_wt_q;

	// Load pipeline stage two
	reg p_v_q;
	reg [1:0] p_k_q;
	reg [TW-1:0] p_tag_q;
	reg [`SFW_OFF_W-1:0] p_off_q;
	reg [1:0] p_sz_q;

	wire [`SFW_DATA_W-1:0] fwd_rdata;
	wire [`SFW_DATA_W-1:0] drn_rdata;
	wire pred_dep;
	wire [`SFW_DATA_W-1:0] mem_shift;
	wire [`SFW_DATA_W-1:0] res_raw;

	wire [AW-1:0] req_addr;
	wire [1:0] req_size;
	wire [AW:0] req_end;
	wire [N-1:0] ov;
	wire [N-1:0] ex;
	reg hit;
	reg [IW-1:0] y;
	integer k;
	integer i;

	assign req_addr = ld_valid ? ld_addr : sl_a_q;
	assign req_size = ld_valid ? ld_size : sl_sz_q;
	assign req_end = {1'b0, req_addr} +
		{{(AW - 3){1'b0}}, sfw_bytes(req_size)};

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1)
		begin : cmp
			wire [AW:0] s_end;
			assign s_end = {1'b0, a_q[g]} +
				{{(AW - 3){1'b0}}, sfw_bytes(sz_q[g])};
			assign ov[g] = v_q[g] && ({1'b0, req_addr} < s_end) &&
				({1'b0, a_q[g]} < req_end);
			assign ex[g] = v_q[g] && (a_q[g] == req_addr) &&
				(req_size <= sz_q[g]);
		end
	endgenerate

	always @*
	begin
		hit = 1'b0;
		y = head_q;
		for (k = 0; k < N; k = k + 1)
		begin
			if (ov[head_q + k[IW-1:0]])
			begin
				hit = 1'b1;
				y = head_q + k[IW-1:0];
			end
		end
	end

	// forward when start and size fit and data exists
	wire fwd_ok = hit && ex[y] && dv_q[y];
	wire data_wait = hit && ex[y] && !dv_q[y];
	wire must_hold = hit && !fwd_ok;
	wire sl_go = slot_busy && !ld_valid && (sl_wt_q == 8'h00);
	wire issue = (ld_valid || sl_go) && !must_hold;
	wire reject = ld_valid && must_hold && slot_busy;
	wire capture = ld_valid && must_hold && !slot_busy;

	sfw_stq_mem #(
		.DW(`SFW_DATA_W),
		.N(N),
		.IW(IW)
	) u_mem (
		.clock(clock),
		.wr_en(st_data_valid),
		.wr_idx(st_data_idx),
		.wr_data(st_data),
		.rd_a_idx(y),
		.rd_a_data(fwd_rdata),
		.rd_b_idx(head_q),
		.rd_b_data(drn_rdata)
	);

	sfw_pred #(
		.ENTRIES(PN),
		.IW(PIW)
	) u_pred (
		.clock(clock),
		.rst(rst),
		.rd_idx(ld_pc[PIW-1:0]),
		.rd_dep(pred_dep),
		.upd_valid(ld_valid),
		.upd_idx(ld_pc[PIW-1:0]),
		.upd_dep(hit && ex[y])
	);

	assign alloc = st_alloc_valid && st_alloc_ready;
	assign pop = (dr_q == `SFW_DR_WRITE) && mem_wr_ready;

	always @*
	begin
		cnt_d = cnt_q;
		if (alloc && !pop)
		begin
			cnt_d = cnt_q + 1'b1;
		end
		else if (pop && !alloc)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always @(posedge clock)
	begin
		if (rst)
		begin
			for (i = 0; i < N; i = i + 1)
			begin
				v_q[i] <= 1'b0;
				ret_q[i] <= 1'b0;
				dv_q[i] <= 1'b0;
				a_q[i] <= {AW{1'b0}};
				sz_q[i] <= 2'h0;
			end
			head_q <= {IW{1'b0}};
			rp_q <= {IW{1'b0}};
			st_alloc_idx <= {IW{1'b0}};
			cnt_q <= {(IW + 1){1'b0}};
			st_alloc_ready <= 1'b1;
			dr_q <= `SFW_DR_IDLE;
			mem_wr_valid <= 1'b0;
			mem_wr_addr <= {AW{1'b0}};
			mem_wr_size <= 2'h0;
			mem_wr_data <= {`SFW_DATA_W{1'b0}};
		end
		else
		begin
			cnt_q <= cnt_d;
			// Full flag comes a cycle late but from the next count
			st_alloc_ready <= (cnt_d != N[IW:0]);
			if (st_data_valid)
			begin
				dv_q[st_data_idx] <= 1'b1;
			end
			if (st_retire && v_q[rp_q] && !ret_q[rp_q])
			begin
				ret_q[rp_q] <= 1'b1;
				rp_q <= rp_q + 1'b1;
			end
			if (pop)
			begin
				v_q[head_q] <= 1'b0;
				ret_q[head_q] <= 1'b0;
				head_q <= head_q + 1'b1;
			end
			if (alloc)
			begin
				v_q[st_alloc_idx] <= 1'b1;
				ret_q[st_alloc_idx] <= 1'b0;
				dv_q[st_alloc_idx] <= 1'b0;
				a_q[st_alloc_idx] <= st_alloc_addr;
				sz_q[st_alloc_idx] <= st_alloc_size;
				st_alloc_idx <= st_alloc_idx + 1'b1;
			end
			case (dr_q)
				`SFW_DR_IDLE:
				begin
					if (v_q[head_q] && ret_q[head_q] && dv_q[head_q])
					begin
						dr_q <= `SFW_DR_READ;
					end
				end
				`SFW_DR_READ:
				begin
					mem_wr_valid <= 1'b1;
					mem_wr_addr <= a_q[head_q];
					mem_wr_size <= sz_q[head_q];
					mem_wr_data <= drn_rdata;
					dr_q <= `SFW_DR_WRITE;
				end
				`SFW_DR_WRITE:
				begin
					if (mem_wr_ready)
					begin
						mem_wr_valid <= 1'b0;
						dr_q <= `SFW_DR_IDLE;
					end
				end
				default:
				begin
					mem_wr_valid <= 1'b0;
					dr_q <= `SFW_DR_IDLE;
				end
			endcase
		end
	end

	// Cache data arrives aligned to the 8-byte word
	assign mem_shift = mem_rd_data >> {p_off_q, 3'b000};
	// store bytes already start at the load address
	assign res_raw = (p_k_q == `SFW_ST_FWD) ? fwd_rdata : mem_shift;

	always @(posedge clock)
	begin
		if (rst)
		begin
			slot_busy <= 1'b0;
			sl_a_q <= {AW{1'b0}};
			sl_sz_q <= 2'h0;
			sl_tag_q <= {TW{1'b0}};
			sl_pred_q <= 1'b0;
			sl_wt_q <= 8'h00;
			p_v_q <= 1'b0;
			p_k_q <= `SFW_ST_MEM;
			p_tag_q <= {TW{1'b0}};
			p_off_q <= {`SFW_OFF_W{1'b0}};
			p_sz_q <= 2'h0;
			mem_rd_valid <= 1'b0;
			mem_rd_addr <= {AW{1'b0}};
			ld_done_valid <= 1'b0;
			ld_done_tag <= {TW{1'b0}};
			ld_done_status <= `SFW_ST_MEM;
			ld_done_data <= {`SFW_DATA_W{1'b0}};
		end
		else
		begin
			if (slot_busy && sl_wt_q != 8'h00)
			begin
				sl_wt_q <= sl_wt_q - 8'h01;
			end
			// new loads win the pipe; the slot retries when idle
			p_v_q <= issue || reject;
			p_tag_q <= ld_valid ? ld_tag : sl_tag_q;
			p_off_q <= req_addr[`SFW_OFF_W-1:0];
			p_sz_q <= req_size;
			p_k_q <= reject ? `SFW_ST_REJ :
				(fwd_ok ? `SFW_ST_FWD : `SFW_ST_MEM);
			// no overlap reads the cache at once
			mem_rd_valid <= issue && !fwd_ok;
			mem_rd_addr <= {req_addr[AW-1:`SFW_OFF_W], 3'b000};
			if (capture)
			begin
				slot_busy <= 1'b1;
				sl_a_q <= ld_addr;
				sl_sz_q <= ld_size;
				sl_tag_q <= ld_tag;
				sl_pred_q <= pred_dep;
				// predicted loads wait free, unpredicted loads waiting on store data pay replay
				sl_wt_q <= (data_wait && !pred_dep) ? `SFW_REPLAY_CYC :
					8'h00;
			end
			else if (sl_go && !must_hold)
			begin
				slot_busy <= 1'b0;
			end
			ld_done_valid <= p_v_q;
			ld_done_tag <= p_tag_q;
			ld_done_status <= p_k_q;
			ld_done_data <= (p_k_q == `SFW_ST_REJ) ?
				{`SFW_DATA_W{1'b0}} : (res_raw & sfw_mask(p_sz_q));
		end
	end

endmodule // sfw_top

// file: tb/sfw_cache_model.sv
/* Cache model for the forwarding block: byte-merging word store.
   Assumes reads are answered while mem_rd_valid is high. */
`timescale 1ns/10ps
module sfw_cache_model (
	input wire clock,
	input wire slow,
	input wire mem_rd_valid,
	input wire [31:0] mem_rd_addr,
	output reg [63:0] mem_rd_data,
	input wire mem_wr_valid,
	input wire [31:0] mem_wr_addr,
	input wire [1:0] mem_wr_size,
	input wire [63:0] mem_wr_data,
	output wire mem_wr_ready
);
reg [63:0] mem_q [0:7];
reg [7:0] cnt_q = 8'h00;
integer b;
initial for (b = 0; b < 8; b = b + 1) mem_q[b] = 64'h0;
// Slow mode accepts one write in four cycles
assign mem_wr_ready = !slow || cnt_q[1:0] == 2'h3;
// Idle bus shows a moving pattern, never stale data
always @*
	mem_rd_data = mem_rd_valid ? mem_q[mem_rd_addr[5:3]] : {8{cnt_q}};
always @(posedge clock)
begin
	cnt_q <= cnt_q + 8'h01;
	if (mem_wr_valid && mem_wr_ready)
		for (b = 0; b < 8; b = b + 1)
			if (b < (1 << mem_wr_size))
				mem_q[mem_wr_addr[5:3]][(mem_wr_addr[2:0] + b) * 8 +: 8]
					<= mem_wr_data[b * 8 +: 8];
end
endmodule // sfw_cache_model

// file: tb/sfw_chk_sva.sv
/* Port checker for the forwarding block.
   Assumes the one-cycle cache of the forwarding block. */
`timescale 1ns/10ps
`include "sfw_map.vh"
module sfw_chk #(parameter AW = 32, parameter IW = 3) (
	input wire clock,
	input wire rst,
	input wire st_retire,
	input wire mem_wr_valid,
	input wire mem_wr_ready,
	input wire [AW-1:0] mem_wr_addr,
	input wire [1:0] mem_wr_size,
	input wire [`SFW_DATA_W-1:0] mem_wr_data,
	input wire ld_valid,
	input wire mem_rd_valid,
	input wire [AW-1:0] mem_rd_addr,
	input wire ld_done_valid,
	input wire [1:0] ld_done_status,
	input wire [`SFW_DATA_W-1:0] ld_done_data,
	input wire slot_busy
);
reg [3:0] ret_q;
wire [3:0] ret_d;
wire wr_acc;
default clocking cb @(posedge clock); endclocking
default disable iff (rst);
assign wr_acc = mem_wr_valid && mem_wr_ready;
// Retired but not yet written stores
assign ret_d = ret_q + {3'h0, st_retire} - {3'h0, wr_acc};
always @(posedge clock)
	ret_q <= rst ? 4'h0 : ret_d;
property p_ld_answer;
	ld_valid && !slot_busy |=> slot_busy or ##1 ld_done_valid;
endproperty
a_ld_answer: assert property (p_ld_answer)
	else $error("load got no answer");
property p_rd_done;
	mem_rd_valid |=> ld_done_valid && ld_done_status == `SFW_ST_MEM;
endproperty
a_rd_done: assert property (p_rd_done)
	else $error("memory read without memory result");
property p_rd_align;
	mem_rd_valid |-> mem_rd_addr[2:0] == 3'h0;
endproperty
a_rd_align: assert property (p_rd_align)
	else $error("memory read not word aligned");
property p_rd_cause;
	mem_rd_valid |-> $past(ld_valid) || $past(slot_busy);
endproperty
a_rd_cause: assert property (p_rd_cause)
	else $error("memory read without a load");
property p_fwd_no_rd;
	ld_done_valid && ld_done_status == `SFW_ST_FWD |-> !$past(mem_rd_valid);
endproperty
a_fwd_no_rd: assert property (p_fwd_no_rd)
	else $error("forwarded load also read memory");
property p_rej_zero;
	ld_done_valid && ld_done_status == `SFW_ST_REJ |-> ld_done_data == 64'h0;
endproperty
a_rej_zero: assert property (p_rej_zero)
	else $error("rejected load carries data");
property p_wr_hold;
	mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr)
		&& $stable(mem_wr_data) && $stable(mem_wr_size);
endproperty
a_wr_hold: assert property (p_wr_hold)
	else $error("write request changed before acceptance");
property p_wr_retired;
	mem_wr_valid |-> ret_q != 4'h0;
endproperty
a_wr_retired: assert property (p_wr_retired)
	else $error("store written before retirement");
property p_wr_gap;
	wr_acc |=> !mem_wr_valid [*2];
endproperty
a_wr_gap: assert property (p_wr_gap)
	else $error("drain writes too close");
endmodule // sfw_chk
bind sfw_top sfw_chk #(.AW(AW), .IW(IW)) u_chk (.clock, .rst, .st_retire,
	.mem_wr_valid, .mem_wr_ready, .mem_wr_addr, .mem_wr_size, .mem_wr_data,
	.ld_valid, .mem_rd_valid, .mem_rd_addr, .ld_done_valid, .ld_done_status,
	.ld_done_data, .slot_busy);

// file: tb/store_load_forwarding_tb_top.sv
/* Self-checking bench of the forwarding block with a cache model.
   Assumes the design files and the cache model are compiled first. */
`timescale 1ns/10ps
`include "sfw_map.vh"
`define CHK(a, b) begin total_checks = total_checks + 1; \
	if ((a) !== (b)) begin error_cnt = error_cnt + 1; \
	$display("mismatch %0t got %h exp %h", $time, a, b); end end
module store_load_forwarding_tb_top;
reg clock, rst, st_alloc_valid, st_data_valid, st_retire, ld_valid, slow;
reg [31:0] st_alloc_addr, ld_addr, ld_pc, seed, cyc;
reg [1:0] st_alloc_size, ld_size, s, ls;
reg [2:0] st_data_idx, ix;
reg [63:0] st_data, d0, d1, d2, d3, d;
reg [5:0] ld_tag, tg;
reg got [0:63];
reg [1:0] gs [0:63];
reg [63:0] gd [0:63];
wire st_alloc_ready, mem_wr_valid, mem_wr_ready, mem_rd_valid;
wire ld_done_valid, slot_busy;
wire [2:0] st_alloc_idx;
wire [31:0] mem_wr_addr, mem_rd_addr;
wire [1:0] mem_wr_size, ld_done_status;
wire [63:0] mem_wr_data, mem_rd_data, ld_done_data;
wire [5:0] ld_done_tag;
integer error_cnt, total_checks, i;
sfw_top dut (
	.clock(clock),
	.rst(rst),
	.st_alloc_valid(st_alloc_valid),
	.st_alloc_addr(st_alloc_addr),
	.st_alloc_size(st_alloc_size),
	.st_alloc_ready(st_alloc_ready),
	.st_alloc_idx(st_alloc_idx),
	.st_data_valid(st_data_valid),
	.st_data_idx(st_data_idx),
	.st_data(st_data),
	.st_retire(st_retire),
	.mem_wr_valid(mem_wr_valid),
	.mem_wr_addr(mem_wr_addr),
	.mem_wr_size(mem_wr_size),
	.mem_wr_data(mem_wr_data),
	.mem_wr_ready(mem_wr_ready),
	.ld_valid(ld_valid),
	.ld_addr(ld_addr),
	.ld_size(ld_size),
	.ld_tag(ld_tag),
	.ld_pc(ld_pc),
	.mem_rd_valid(mem_rd_valid),
	.mem_rd_addr(mem_rd_addr),
	.mem_rd_data(mem_rd_data),
	.ld_done_valid(ld_done_valid),
	.ld_done_tag(ld_done_tag),
	.ld_done_status(ld_done_status),
	.ld_done_data(ld_done_data),
	.slot_busy(slot_busy)
);
sfw_cache_model cm (
	.clock(clock),
	.slow(slow),
	.mem_rd_valid(mem_rd_valid),
	.mem_rd_addr(mem_rd_addr),
	.mem_rd_data(mem_rd_data),
	.mem_wr_valid(mem_wr_valid),
	.mem_wr_addr(mem_wr_addr),
	.mem_wr_size(mem_wr_size),
	.mem_wr_data(mem_wr_data),
	.mem_wr_ready(mem_wr_ready)
);
function [31:0] xs;
begin
	seed = seed ^ (seed << 13);
	seed = seed ^ (seed >> 17);
	seed = seed ^ (seed << 5);
	xs = seed;
end
endfunction
function [63:0] msk(input [1:0] z);
	msk = (z == 2'h3) ? ~64'h0 : (64'h1 << (8 << z)) - 64'h1;
endfunction
task tally_and_finish;
begin
	if (error_cnt == 0 && total_checks > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
end
endtask
task st(input [31:0] a, input [1:0] z, input [63:0] v, input g);
begin
	@(posedge clock);
	st_alloc_valid <= 1'b1;
	st_alloc_addr <= a;
	st_alloc_size <= z;
	@(posedge clock);
	st_alloc_valid <= 1'b0;
	st_data_valid <= g;
	st_data_idx <= ix;
	st_data <= v;
	ix = ix + 3'h1;
	@(posedge clock);
	st_data_valid <= 1'b0;
end
endtask
task sd(input [2:0] k, input [63:0] v);
begin
	@(posedge clock);
	st_data_valid <= 1'b1;
	st_data_idx <= k;
	st_data <= v;
	@(posedge clock);
	st_data_valid <= 1'b0;
end
endtask
task rt;
begin
	@(posedge clock);
	st_retire <= 1'b1;
	@(posedge clock);
	st_retire <= 1'b0;
end
endtask
task ld(input [31:0] a, input [1:0] z);
begin
	@(posedge clock);
	ld_valid <= 1'b1;
	ld_addr <= a;
	ld_size <= z;
	ld_tag <= tg;
	ld_pc <= a;
	@(posedge clock);
	ld_valid <= 1'b0;
	tg = tg + 6'h01;
end
endtask
task ex(input [5:0] t, input [1:0] z, input [63:0] v);
integer k;
begin
	for (k = 0; k < 400 && got[t] !== 1'b1; k = k + 1)
		@(posedge clock);
	`CHK(gs[t], z)
	`CHK(gd[t], v)
end
endtask
initial
begin
	clock = 1'b0;
	forever #2 clock = ~clock;
end
always @(posedge clock)
begin
	cyc = cyc + 32'h1;
	if (ld_done_valid)
	begin
		got[ld_done_tag] <= 1'b1;
		gs[ld_done_tag] <= ld_done_status;
		gd[ld_done_tag] <= ld_done_data;
	end
	// Hang guard well above the run length
	if (cyc == 32'h4E20)
	begin
		error_cnt = error_cnt + 1;
		tally_and_finish;
	end
end
initial
begin
	{rst, slow} = 2'h3;
	{st_alloc_valid, st_data_valid, st_retire, ld_valid} = 4'h0;
	{st_alloc_addr, ld_addr, ld_pc, cyc} = 128'h0;
	{st_alloc_size, ld_size, st_data_idx, ld_tag, st_data} = 77'h0;
	{ix, tg, error_cnt, total_checks} = 73'h0;
	seed = 32'h000126EC;
	for (i = 0; i < 64; i = i + 1) got[i] = 1'b0;
	repeat (4) @(posedge clock);
	rst <= 1'b0;
	d0 = {xs(), xs()};
	d1 = {xs(), xs()};
	d2 = {xs(), xs()};
	d3 = {xs(), xs()};
	st(32'h40, 2'h2, d0, 1'b1);
	st(32'h40, 2'h0, d1, 1'b1);
	st(32'h48, 2'h0, d2, 1'b1);
	st(32'h49, 2'h0, d3, 1'b1);
	ld(32'h41, 2'h0);
	ld(32'h40, 2'h0);
	ld(32'h48, 2'h1);
	ld(32'h78, 2'h3);
	ex(6'h01, `SFW_ST_FWD, d1 & msk(2'h0));
	ex(6'h02, `SFW_ST_REJ, 64'h0);
	ex(6'h03, `SFW_ST_MEM, 64'h0);
	`CHK(got[0], 1'b0)
	`CHK(slot_busy, 1'b1)
	rt;
	rt;
	ex(6'h00, `SFW_ST_MEM, (d0 >> 8) & msk(2'h0));
	ld(32'h48, 2'h1);
	repeat (20) @(posedge clock);
	`CHK(got[4], 1'b0)
	rt;
	rt;
	ex(6'h04, `SFW_ST_MEM, {48'h0, d3[7:0], d2[7:0]});
	// First pass pays the replay, second runs with the predictor trained
	for (i = 0; i < 2; i = i + 1)
	begin
		d = {xs(), xs()};
		st(32'h54, 2'h2, d, 1'b0);
		ld(32'h54, 2'h2);
		repeat (20) @(posedge clock);
		`CHK(got[tg - 6'h01], 1'b0)
		sd(ix - 3'h1, d);
		ex(tg - 6'h01, `SFW_ST_FWD, d & msk(2'h2));
		rt;
	end
	slow <= 1'b0;
	for (i = 0; i < 8; i = i + 1)
	begin
		s = xs() & 32'h3;
		ls = xs() % ({30'h0, s} + 32'h1);
		d = {xs(), xs()};
		st(32'h60, s, d, 1'b1);
		ld(32'h60, ls);
		ex(tg - 6'h01, `SFW_ST_FWD, d & msk(ls));
		rt;
	end
	tally_and_finish;
end
endmodule // store_load_forwarding_tb_top
